// ==== hdl/imsc_top.sv ====
// I2C master sequence control with AXI4-Lite registers and a sticky interrupt.
// Assumes open-drain pads outside: an output enable low pulls the line low.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module imsc_top
  import imsc_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  output logic             irq
);

  if (QUARTER < 4 || QUARTER > 4095) begin
    $error("QUARTER out of range");
  end

  function automatic logic reg_hit(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= ADDR_IRQ_MASK);
  endfunction

  // ---------------------------------------------------------------
  // Bus line sampling
  // ---------------------------------------------------------------
  imsc_pins_s pin_raw;
  imsc_pins_s pin_s;
  imsc_pins_s prev_ff;

  assign pin_raw = '{scl: scl_i, sda: sda_i};

  imsc_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (pin_raw),
    .dout    (pin_s)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic        aw_have_ff;
  logic        w_have_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic        wlane0_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        wr_fire;
  logic        wr_en;

  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready  = !w_have_ff && !bvalid_ff;
  assign wr_fire       = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_en         = wr_fire && wlane0_ff && reg_hit(awaddr_ff);
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wlane0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wlane0_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= reg_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  imsc_state_e      state_ff;
  logic             busy;
  logic             gcie_ff;
  logic             ackval_ff;
  logic             stretch_en_ff;
  logic             master_ff;
  logic             ackrx_ff;
  logic [7:0]       rxdata_ff;
  logic [EV_W-1:0]  status_ff;
  logic [EV_W-1:0]  mask_ff;
  logic             wr_seq;
  logic             wr_tx;

  assign busy   = (state_ff != ST_IDLE);
  assign wr_seq = wr_en && (awaddr_ff == ADDR_SEQ_CTRL);
  assign wr_tx  = wr_en && (awaddr_ff == ADDR_TX_BUF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gcie_ff       <= SEQ_CTRL_RST[SC_GCIE];
      ackval_ff     <= SEQ_CTRL_RST[SC_ACKVAL];
      stretch_en_ff <= SEQ_CTRL_RST[SC_SOS];
      master_ff     <= MASTER_RST;
      mask_ff       <= IRQ_MASK_RST;
    end else if (wr_en) begin
      if (wr_seq) begin
        gcie_ff   <= wdata_ff[SC_GCIE];
        ackval_ff <= wdata_ff[SC_ACKVAL];
        if (!master_ff) begin
          stretch_en_ff <= wdata_ff[SC_SOS];
        end
      end
      // Mode change mid-sequence would strand the lines, so only when idle
      if (awaddr_ff == ADDR_CONFIG && !busy) begin
        master_ff <= wdata_ff[CFG_MASTER];
      end
      if (awaddr_ff == ADDR_IRQ_MASK) begin
        mask_ff <= wdata_ff[EV_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Master sequence engine
  // ---------------------------------------------------------------
  logic [11:0] qcnt_ff;
  logic [1:0]  phase_ff;
  logic [3:0]  bit_ff;
  logic [7:0]  shreg_ff;
  logic        scl_rel_ff;
  logic        sda_rel_ff;
  logic        hold;
  logic        qtick;
  logic [1:0]  last_phase;
  logic [3:0]  last_bit;
  logic        done;

  // Another device stretching SCL pauses the quarter timer
  assign hold  = scl_rel_ff && !pin_s.scl;
  assign qtick = busy && !hold && (qcnt_ff == 12'(QUARTER - 1));

  always_comb begin
    case (state_ff)
      ST_START: last_phase = 2'd1;
      ST_STOP:  last_phase = 2'd2;
      default:  last_phase = 2'd3;
    endcase
    case (state_ff)
      ST_TX:   last_bit = 4'd8;
      ST_RX:   last_bit = 4'd7;
      default: last_bit = 4'd0;
    endcase
  end

  assign done = qtick && (phase_ff == last_phase) && (bit_ff == last_bit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= ST_IDLE;
      qcnt_ff    <= 12'h000;
      phase_ff   <= 2'd0;
      bit_ff     <= 4'h0;
      shreg_ff   <= 8'h00;
      scl_rel_ff <= 1'b1;
      sda_rel_ff <= 1'b1;
      ackrx_ff   <= 1'b0;
      rxdata_ff  <= 8'h00;
    end else if (!busy) begin
      qcnt_ff  <= 12'h000;
      phase_ff <= 2'd0;
      bit_ff   <= 4'h0;
      // Only one request is taken; lower priority bits written with it are dropped
      if (master_ff && wr_seq) begin
        if (wdata_ff[SC_SOS]) begin
          state_ff <= ST_START;
        end else if (wdata_ff[SC_RPT]) begin
          state_ff <= ST_RSTART;
        end else if (wdata_ff[SC_STOP]) begin
          state_ff <= ST_STOP;
        end else if (wdata_ff[SC_RXREQ]) begin
          state_ff <= ST_RX;
        end else if (wdata_ff[SC_ACKREQ]) begin
          state_ff <= ST_ACK;
        end
      end else if (master_ff && wr_tx) begin
        shreg_ff <= wdata_ff[7:0];
        state_ff <= ST_TX;
      end
    end else begin
      // Busy: request and buffer writes fall through untouched
      if (!hold) begin
        qcnt_ff <= qtick ? 12'h000 : qcnt_ff + 12'h001;
      end
      if (qtick) begin
        phase_ff <= phase_ff + 2'd1;
        case (state_ff)
          ST_START: begin
            if (phase_ff == 2'd0) sda_rel_ff <= 1'b0;
            else scl_rel_ff <= 1'b0;
          end
          ST_RSTART: begin
            case (phase_ff)
              2'd0:    sda_rel_ff <= 1'b1;
              2'd1:    scl_rel_ff <= 1'b1;
              2'd2:    sda_rel_ff <= 1'b0;
              default: scl_rel_ff <= 1'b0;
            endcase
          end
          ST_STOP: begin
            case (phase_ff)
              2'd0:    sda_rel_ff <= 1'b0;
              2'd1:    scl_rel_ff <= 1'b1;
              default: sda_rel_ff <= 1'b1;
            endcase
          end
          ST_TX, ST_RX, ST_ACK: begin
            case (phase_ff)
              2'd0: begin
                if (state_ff == ST_ACK) begin
                  sda_rel_ff <= ackval_ff;
                end else if (state_ff == ST_TX && bit_ff != 4'd8) begin
                  sda_rel_ff <= shreg_ff[7];
                end else begin
                  sda_rel_ff <= 1'b1;
                end
              end
              2'd1: scl_rel_ff <= 1'b1;
              2'd2: begin
                if (state_ff == ST_TX && bit_ff == 4'd8) begin
                  ackrx_ff <= pin_s.sda;
                end
                if (state_ff == ST_RX) begin
                  shreg_ff <= {shreg_ff[6:0], pin_s.sda};
                end
                if (state_ff == ST_TX && bit_ff != 4'd8) begin
                  shreg_ff <= {shreg_ff[6:0], 1'b0};
                end
              end
              default: begin
                scl_rel_ff <= 1'b0;
                bit_ff     <= bit_ff + 4'h1;
                if (state_ff == ST_RX && bit_ff == 4'd7) begin
                  rxdata_ff <= shreg_ff;
                end
              end
            endcase
          end
          default: ;
        endcase
        if (done) begin
          state_ff <= ST_IDLE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Slave-side bus monitor and clock stretch
  // ---------------------------------------------------------------
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       slv_active_ff;
  logic       slv_addr_ff;
  logic [3:0] slv_bits_ff;
  logic [7:0] slv_sh_ff;
  logic       stretch_ff;
  logic       slv_byte;
  logic       gcall;

  assign scl_rise  = pin_s.scl && !prev_ff.scl;
  assign scl_fall  = !pin_s.scl && prev_ff.scl;
  assign start_det = prev_ff.sda && !pin_s.sda && pin_s.scl && prev_ff.scl;
  assign stop_det  = !prev_ff.sda && pin_s.sda && pin_s.scl && prev_ff.scl;
  assign slv_byte  = scl_rise && slv_active_ff && !master_ff && (slv_bits_ff == 4'd7);
  assign gcall     = slv_byte && slv_addr_ff && gcie_ff
                     && ({slv_sh_ff[6:0], pin_s.sda} == GCALL_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff       <= '{scl: 1'b1, sda: 1'b1};
      slv_active_ff <= 1'b0;
      slv_addr_ff   <= 1'b0;
      slv_bits_ff   <= 4'h0;
      slv_sh_ff     <= 8'h00;
    end else begin
      prev_ff <= pin_s;
      if (start_det) begin
        slv_active_ff <= 1'b1;
        slv_addr_ff   <= 1'b1;
        slv_bits_ff   <= 4'h0;
      end else if (stop_det) begin
        slv_active_ff <= 1'b0;
      end else if (scl_rise && slv_active_ff) begin
        if (slv_bits_ff == 4'd8) begin
          slv_bits_ff <= 4'h0;
          slv_addr_ff <= 1'b0;
        end else begin
          slv_bits_ff <= slv_bits_ff + 4'h1;
          slv_sh_ff   <= {slv_sh_ff[6:0], pin_s.sda};
        end
      end
    end
  end

  // Held low after the eighth clock until software clears the slave byte flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stretch_ff <= 1'b0;
    end else if (scl_fall && slv_active_ff && !master_ff && stretch_en_ff
                 && slv_bits_ff == 4'd8) begin
      stretch_ff <= 1'b1;
    end else if (!status_ff[EV_SLV_BYTE] || master_ff || !stretch_en_ff) begin
      stretch_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and output
  // ---------------------------------------------------------------
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic            irq_ff;

  always_comb begin
    ev_set              = '0;
    ev_set[EV_SEQ_DONE] = done;
    ev_set[EV_RX_BYTE]  = done && (state_ff == ST_RX);
    ev_set[EV_GCALL]    = gcall;
    ev_set[EV_NACK]     = done && (state_ff == ST_TX) && ackrx_ff;
    ev_set[EV_SLV_BYTE] = slv_byte;
  end

  assign ev_clr = (wr_en && awaddr_ff == ADDR_IRQ_STATUS) ? wdata_ff[EV_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
      irq_ff    <= 1'b0;
    end else begin
      // Set beats a simultaneous write-one clear
      status_ff <= (status_ff & ~ev_clr) | ev_set;
      irq_ff    <= |(status_ff & mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rd_word;
  logic [7:0]  seq_view;

  always_comb begin
    seq_view            = 8'h00;
    seq_view[SC_GCIE]   = gcie_ff;
    seq_view[SC_ACKRX]  = ackrx_ff;
    seq_view[SC_ACKVAL] = ackval_ff;
    seq_view[SC_ACKREQ] = (state_ff == ST_ACK);
    seq_view[SC_RXREQ]  = (state_ff == ST_RX);
    seq_view[SC_STOP]   = (state_ff == ST_STOP);
    seq_view[SC_RPT]    = (state_ff == ST_RSTART);
    seq_view[SC_SOS]    = master_ff ? (state_ff == ST_START) : stretch_en_ff;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_SEQ_CTRL:   rd_word[7:0] = seq_view;
      ADDR_RX_DATA:    rd_word[7:0] = rxdata_ff;
      ADDR_CONFIG:     rd_word[1:0] = {busy, master_ff};
      ADDR_IRQ_STATUS: rd_word[EV_W-1:0] = status_ff;
      ADDR_IRQ_MASK:   rd_word[EV_W-1:0] = mask_ff;
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Pads
  // ---------------------------------------------------------------
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_n = scl_rel_ff && !stretch_ff;
  assign sda_oe_n = sda_rel_ff;
  assign irq      = irq_ff;

endmodule

// ==== hdl/imsc_pkg.sv ====
// Constants, types and register map of the I2C master sequence control block.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data.
// Operation
// - In slave mode with general call enabled, a received address byte of 0x00 raises the interrupt.
// - A stop request in master mode makes a Stop condition and clears itself when it ends.
// - A repeated start request in master mode makes a Repeated Start and clears itself when done.
// - In slave mode the start/stretch bit turns clock stretching on when set and off when clear.
// - While the port is busy, attempts to set any request bit are ignored and never queued.
// - While the port is busy, writes to the transmit buffer are discarded.
package imsc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SEQ_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TX_BUF     = 8'h04;
  localparam logic [7:0] ADDR_RX_DATA    = 8'h08;
  localparam logic [7:0] ADDR_CONFIG     = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SC_GCIE    = 7;
  localparam int SC_ACKRX   = 6;
  localparam int SC_ACKVAL  = 5;
  localparam int SC_ACKREQ  = 4;
  localparam int SC_RXREQ   = 3;
  localparam int SC_STOP    = 2;
  localparam int SC_RPT     = 1;
  localparam int SC_SOS     = 0;
  localparam int CFG_MASTER = 0;
  localparam int CFG_BUSY   = 1;
  localparam int EV_SEQ_DONE = 0;
  localparam int EV_RX_BYTE  = 1;
  localparam int EV_GCALL    = 2;
  localparam int EV_NACK     = 3;
  localparam int EV_SLV_BYTE = 4;
  localparam int EV_W        = 5;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0]      SEQ_CTRL_RST = 8'h00;
  localparam logic            MASTER_RST   = 1'b0;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 5'h00;
  localparam logic [7:0]      GCALL_ADDR   = 8'h00;
  localparam logic [1:0]      RESP_OKAY    = 2'b00;
  localparam logic [1:0]      RESP_SLVERR  = 2'b10;

  // ---------------------------------------------------------------
  // Timing: one quarter of an SCL period, rounded up to whole cycles
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int QUARTER_NS     = 2500;
  localparam int QUARTER_CYCLES = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_RSTART = 3'b010,
    ST_STOP   = 3'b011,
    ST_TX     = 3'b100,
    ST_RX     = 3'b101,
    ST_ACK    = 3'b110
  } imsc_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } imsc_pins_s;

endpackage

// ==== hdl/imsc_sync.sv ====
// Three-stage synchroniser for the sampled bus lines.
// Assumes the inputs are asynchronous to aclk; output moves only when stages two and three agree.
`timescale 1ns/100ps
module imsc_sync
  import imsc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire imsc_pins_s din,
  output imsc_pins_s      dout
);

  imsc_pins_s s1_ff;
  imsc_pins_s s2_ff;
  imsc_pins_s s3_ff;
  imsc_pins_s out_ff;

  // Released bus reads high, so reset to that level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff  <= '{scl: 1'b1, sda: 1'b1};
      s2_ff  <= '{scl: 1'b1, sda: 1'b1};
      s3_ff  <= '{scl: 1'b1, sda: 1'b1};
      out_ff <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff.scl == s3_ff.scl) begin
        out_ff.scl <= s3_ff.scl;
      end
      if (s2_ff.sda == s3_ff.sda) begin
        out_ff.sda <= s3_ff.sda;
      end
    end
  end

  assign dout = out_ff;

endmodule

// ==== testbench/imsc_sva.sv ====
// Checker for the register bus handshakes and pad outputs of imsc_top.
// Assumes it is bound to imsc_top and sees only its ports.
`timescale 1ns/100ps
module imsc_sva
  import imsc_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        scl_o,
  input wire logic        sda_o,
  input wire logic        scl_oe_n,
  input wire logic        sda_oe_n,
  input wire logic        irq
);
  // ---------------------------------------------------------------
  // Handshake and pad checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_rst_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && scl_oe_n && sda_oe_n)
    else $error("pads or irq active after reset");
  chk_wr_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted with response pending");
  chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_od_low: assert property (!scl_o && !sda_o)
    else $error("open drain output not low");
endmodule

bind imsc_top imsc_sva #(.QUARTER(QUARTER)) i_imsc_sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .scl_o, .sda_o, .scl_oe_n, .sda_oe_n, .irq
);

// ==== testbench/imsc_bus.sv ====
// Behavioural I2C bus: pull-ups, a slave that acks or sends a byte, a simple master.
// Assumes open-drain enables from the device, low meaning pull low.
`timescale 1ns/100ps
module imsc_bus (
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda
);
  logic       m_scl = 1'b1, m_sda = 1'b1, s_sda = 1'b1;
  logic       ack_nack = 1'b0, slv_tx = 1'b0, cap_ack = 1'b1;
  logic [7:0] rx_byte = 8'h00, cap_byte = 8'h00, sh = 8'h00;
  int         cnt = 0, stops = 0;

  // Released lines float high through the pull-ups
  assign scl = scl_oe_n & m_scl;
  assign sda = sda_oe_n & m_sda & s_sda;

  always @(negedge sda) if (scl) begin
    cnt = 0;
    stops = 0;
  end
  always @(posedge sda) if (scl) stops++;
  always @(posedge scl) begin
    if (cnt == 8) cap_ack = sda;
    else sh = {sh[6:0], sda};
    cnt++;
    if (cnt == 8) cap_byte = sh;
  end
  // Data only changes while SCL is low, so no false start or stop
  always @(negedge scl) begin
    if (cnt == 9) begin
      cnt = 0;
      s_sda = 1'b1;
    end else if (cnt == 8) s_sda = slv_tx | ack_nack;
    else s_sda = !slv_tx | rx_byte[7-cnt];
  end

  // Master role: start and eight bits at a 125 ns bit time, SCL left low
  task automatic mbyte(input logic [7:0] b);
    #2 m_sda = 1'b0;
    #63 m_scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #31 m_sda = b[i];
      #31 m_scl = 1'b1;
      #63 m_scl = 1'b0;
    end
    #100;
  endtask
  task automatic mstop;
    #31 m_sda = 1'b0;
    #31 m_scl = 1'b1;
    #63 m_sda = 1'b1;
  endtask
endmodule

// ==== testbench/imsc_top_tb.sv ====
// Bench for imsc_top: register accesses over AXI4-Lite and the bus sequences they start.
// Assumes imsc_bus on the pins and the checker bound by its own file.
`timescale 1ns/100ps
module imsc_top_tb
  import imsc_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        scl_i, sda_i, scl_o, sda_o, scl_oe_n, sda_oe_n, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          error_cnt = 0, compares = 0, cyc = 0;
  // Slave cases: control, address byte, status, SCL enable before and after clear
  logic [31:0] sv [3] = '{32'h81001401, 32'h80551003, 32'h01001001};

  imsc_top #(.QUARTER(16)) i_imsc_top (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .scl_i, .scl_o, .scl_oe_n, .sda_i, .sda_o, .sda_oe_n, .irq);
  imsc_bus i_imsc_bus (.scl_oe_n, .sda_oe_n, .scl(scl_i), .sda(sda_i));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp("rdata", e, s_axi_rdata);
    cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  // Later events of one sequence land within a quarter, hence the settle wait
  task automatic ev(input logic [31:0] st, input logic [1:0] oe);
    while (irq !== 1'b1) @(posedge aclk);
    repeat (40) @(posedge aclk);
    rd(ADDR_IRQ_STATUS, st, RESP_OKAY);
    cmp("scl_hold", {31'h0, oe[1]}, {31'h0, scl_oe_n});
    wr(ADDR_IRQ_STATUS, st, RESP_OKAY);
    repeat (4) @(posedge aclk);
    cmp("scl_free", {31'h0, oe[0]}, {31'h0, scl_oe_n});
    cmp("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      $display("FAIL run_length expected done seen hang");
      end_of_test();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_SEQ_CTRL, {24'h0, SEQ_CTRL_RST}, RESP_OKAY);
    rd(ADDR_IRQ_MASK, {27'h0, IRQ_MASK_RST}, RESP_OKAY);
    rd(ADDR_CONFIG, 32'h0, RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h1, RESP_SLVERR);
    $display("test registers done");
    wr(ADDR_CONFIG, 32'h1, RESP_OKAY);
    wr(ADDR_SEQ_CTRL, 32'h1, RESP_OKAY);
    rd(ADDR_SEQ_CTRL, 32'h1, RESP_OKAY);
    wr(ADDR_SEQ_CTRL, 32'h4, RESP_OKAY);
    wr(ADDR_TX_BUF, 32'hFF, RESP_OKAY);
    rd(ADDR_CONFIG, 32'h3, RESP_OKAY);
    repeat (40) @(posedge aclk);
    rd(ADDR_SEQ_CTRL, 32'h0, RESP_OKAY);
    cmp("bits_on_bus", 32'h0, i_imsc_bus.cnt);
    cmp("stops", 32'h0, i_imsc_bus.stops);
    cmp("irq_masked", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h1F, RESP_OKAY);
    ev(32'h1, 2'b00);
    $display("test start and busy done");
    for (int k = 0; k < 2; k++) begin
      i_imsc_bus.ack_nack <= (k == 0);
      wr(ADDR_TX_BUF, k ? 32'h5A : 32'hA5, RESP_OKAY);
      ev(k ? 32'h01 : 32'h09, 2'b00);
      cmp("tx_byte", k ? 32'h5A : 32'hA5, {24'h0, i_imsc_bus.cap_byte});
      rd(ADDR_SEQ_CTRL, k ? 32'h00 : 32'h40, RESP_OKAY);
    end
    $display("test transmit done");
    i_imsc_bus.slv_tx  <= 1'b1;
    i_imsc_bus.rx_byte <= 8'h3C;
    wr(ADDR_SEQ_CTRL, 32'h2, RESP_OKAY);
    rd(ADDR_SEQ_CTRL, 32'h2, RESP_OKAY);
    ev(32'h1, 2'b00);
    rd(ADDR_SEQ_CTRL, 32'h0, RESP_OKAY);
    wr(ADDR_SEQ_CTRL, 32'h8, RESP_OKAY);
    ev(32'h3, 2'b00);
    rd(ADDR_RX_DATA, 32'h3C, RESP_OKAY);
    i_imsc_bus.cap_ack <= 1'b1;
    wr(ADDR_SEQ_CTRL, 32'h10, RESP_OKAY);
    ev(32'h1, 2'b00);
    cmp("ack_bit", 32'h0, {31'h0, i_imsc_bus.cap_ack});
    i_imsc_bus.slv_tx <= 1'b0;
    wr(ADDR_SEQ_CTRL, 32'h4, RESP_OKAY);
    rd(ADDR_SEQ_CTRL, 32'h4, RESP_OKAY);
    ev(32'h1, 2'b11);
    rd(ADDR_SEQ_CTRL, 32'h0, RESP_OKAY);
    cmp("stops", 32'h1, i_imsc_bus.stops);
    $display("test receive and stop done");
    wr(ADDR_CONFIG, 32'h0, RESP_OKAY);
    i_imsc_bus.ack_nack <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_SEQ_CTRL, {24'h0, sv[k][31:24]}, RESP_OKAY);
      i_imsc_bus.mbyte(sv[k][23:16]);
      ev({24'h0, sv[k][15:8]}, sv[k][1:0]);
      i_imsc_bus.mstop();
    end
    $display("test slave done");
    end_of_test();
  end
endmodule
